// >>> core/ncps_defines.vh
// Summary of operation
// - A page load opens with the serial data input command 80h.
// - After address and data, command 15h starts a cached program instead of plain.
// - A first-plane block address change while a cached series is open refuses the start and sets the error flag.
// - Command 10h ends the series; ready then means the last page is programmed.
// - Whole blocks: repeat steps per page, end with 81h then 10h.
// - At most one block per district for each page pair.
// - Both districts get identical page-in-block bits.
// - A multi-page cached series always ends with 10h.
// - Once started, only the series' own commands plus status and reset.
// - Between 11h and 81h only status read or reset may be issued.
`ifndef NCPS_DEFINES_VH
`define NCPS_DEFINES_VH

`define NCPS_CMD_DIN      8'h80
`define NCPS_CMD_PLANE2   8'h81
`define NCPS_CMD_PLANE_SW 8'h11
`define NCPS_CMD_CACHE    8'h15
`define NCPS_CMD_FINAL    8'h10
`define NCPS_CMD_STAT     8'h70
`define NCPS_CMD_STAT_MP  8'h71

`define NCPS_OFF_CTRL     8'h00
`define NCPS_OFF_ROW_A    8'h04
`define NCPS_OFF_ROW_B    8'h08
`define NCPS_OFF_DATA     8'h0c
`define NCPS_OFF_LEN      8'h10
`define NCPS_OFF_STATUS   8'h14

`define NCPS_CTRL_GO      0
`define NCPS_CTRL_FINAL   1
`define NCPS_CTRL_MULTI   2
`define NCPS_CTRL_STATONLY 3
`define NCPS_ST_BUSY      8
`define NCPS_ST_RB        9
`define NCPS_ST_OPEN      10
`define NCPS_ST_ERR       11
`define NCPS_ST_OPEN_MULTI 12
`define NCPS_LEN_RST      12'h100

`define NCPS_CLK_MHZ      40
`define NCPS_T_WB_NS      100
`define NCPS_WB_CYC       ((`NCPS_T_WB_NS * `NCPS_CLK_MHZ + 999) / 1000)
`define NCPS_STROBE_LOW   4'h4
`define NCPS_STROBE_HIGH  4'h2

`endif

// >>> core/ncps_byte_cycle.v
`include "ncps_defines.vh"

module ncps_byte_cycle (
  input  wire       pclk,
  input  wire       presetn,
  input  wire       start,
  input  wire       rd,
  input  wire       cle_in,
  input  wire       ale_in,
  input  wire [7:0] wbyte,
  output reg        done,
  output reg  [7:0] rbyte,
  output wire       nand_cle,
  output wire       nand_ale,
  output wire       nand_we_n,
  output wire       nand_re_n,
  output reg  [7:0] nand_io_out,
  output wire       nand_io_oe_n,
  input  wire [7:0] nand_io_in
);
  localparam [3:0] LOW_CYC  = `NCPS_STROBE_LOW;
  localparam [3:0] HIGH_CYC = `NCPS_STROBE_HIGH;

  reg       act_q;
  reg       ph_q;
  reg [3:0] cnt_q;
  reg       rd_q;
  reg       cle_q;
  reg       ale_q;
  reg [7:0] io_s1_q;
  reg [7:0] io_s2_q;

  // Read strobe low spans more than the two sync stages, so data is settled when sampled
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      io_s1_q <= 8'h00;
      io_s2_q <= 8'h00;
    end else begin
      io_s1_q <= nand_io_in;
      io_s2_q <= io_s1_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      act_q       <= 1'b0;
      ph_q        <= 1'b0;
      cnt_q       <= 4'h0;
      rd_q        <= 1'b0;
      cle_q       <= 1'b0;
      ale_q       <= 1'b0;
      nand_io_out <= 8'h00;
      rbyte       <= 8'h00;
      done        <= 1'b0;
    end else begin
      done <= 1'b0;
      if (start && !act_q) begin
        act_q       <= 1'b1;
        ph_q        <= 1'b0;
        cnt_q       <= 4'h0;
        rd_q        <= rd;
        cle_q       <= cle_in;
        ale_q       <= ale_in;
        nand_io_out <= wbyte;
      end else if (act_q) begin
        cnt_q <= cnt_q + 4'h1;
        if (!ph_q && cnt_q == LOW_CYC - 4'h1) begin
          ph_q  <= 1'b1;
          cnt_q <= 4'h0;
          if (rd_q) begin
            rbyte <= io_s2_q;
          end
        end else if (ph_q && cnt_q == HIGH_CYC - 4'h1) begin
          act_q <= 1'b0;
          done  <= 1'b1;
        end
      end
    end
  end

  // Latches and write data stay through the high phase to cover hold time
  assign nand_cle     = act_q & cle_q;
  assign nand_ale     = act_q & ale_q;
  assign nand_we_n    = ~(act_q & ~ph_q & ~rd_q);
  assign nand_re_n    = ~(act_q & ~ph_q & rd_q);
  assign nand_io_oe_n = ~(act_q & ~rd_q);
endmodule // ncps_byte_cycle

// >>> core/ncps_host.v
// The register addresses and the APB slave port were chosen for this implementation.
`include "ncps_defines.vh"

module ncps_host (
  input  wire        pclk,
  input  wire        presetn,
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [7:0]  paddr,
  input  wire [31:0] pwdata,
  output reg  [31:0] prdata,
  output wire        pready,
  output reg         pslverr,
  output wire        nand_ce_n,
  output wire        nand_cle,
  output wire        nand_ale,
  output wire        nand_we_n,
  output wire        nand_re_n,
  output wire        nand_wp_n,
  output wire [7:0]  nand_io_out,
  output wire        nand_io_oe_n,
  input  wire [7:0]  nand_io_in,
  input  wire        ready_busy_pin,
  output wire        busy
);
  localparam [2:0] S_IDLE  = 3'd0;
  localparam [2:0] S_WAIT  = 3'd1;
  localparam [2:0] S_SEQ   = 3'd2;
  localparam [2:0] S_ADDR  = 3'd3;
  localparam [2:0] S_DATA  = 3'd4;
  localparam [2:0] S_END   = 3'd5;
  localparam [2:0] S_SCMD  = 3'd6;
  localparam [2:0] S_SRD   = 3'd7;
  localparam integer WB_CYC_INT = `NCPS_WB_CYC;
  localparam [7:0]   WB_CYC     = WB_CYC_INT[7:0];

  reg [2:0]  state_q;
  reg [2:0]  ret_q;
  reg [2:0]  idx_q;
  reg [11:0] cnt_q;
  reg [11:0] len_q;
  reg        plane_q;
  reg        final_q;
  reg        multi_q;
  reg        stonly_q;
  reg [16:0] row_a_q;
  reg [16:0] row_b_q;
  reg [7:0]  data_q;
  reg        pend_q;
  reg [7:0]  stat_q;
  reg        open_q;
  reg        open_multi_q;
  reg [10:0] open_blk_q;
  reg        err_q;
  reg        launch_q;
  reg [7:0]  wb_q;
  reg        rb_s1_q;
  reg        rb_s2_q;

  wire       bc_done;
  wire [7:0] bc_rbyte;
  reg  [7:0] bc_byte;
  reg        bc_cle;
  reg        bc_ale;
  reg        bc_need;
  reg  [16:0] row;

  wire access   = psel & penable;
  wire wr_data  = access & pwrite & (paddr == `NCPS_OFF_DATA);
  wire wr_ctrl  = access & pwrite & (paddr == `NCPS_OFF_CTRL);
  wire go       = wr_ctrl & pwdata[`NCPS_CTRL_GO];
  wire go_multi = pwdata[`NCPS_CTRL_MULTI];
  wire go_stat  = pwdata[`NCPS_CTRL_STATONLY];
  wire blk_chg  = open_q & (row_a_q[16:6] != open_blk_q);
  wire mode_chg = open_q & (go_multi != open_multi_q);
  wire same_dst = go_multi & (row_a_q[6] == row_b_q[6]);
  wire go_ok    = (state_q == S_IDLE) & (go_stat | ~(blk_chg | mode_chg | same_dst));
  wire bc_start = bc_need & ~launch_q;

  // Data writes stall the bus while the previous byte is still on the pins
  assign pready    = ~(wr_data & pend_q);
  assign busy      = (state_q != S_IDLE);
  assign nand_ce_n = ~busy;
  assign nand_wp_n = 1'b1;

  // Second plane borrows the first plane's page bits, only the block differs
  always @* begin
    row = plane_q ? {row_b_q[16:6], row_a_q[5:0]} : row_a_q;
  end

  always @* begin
    bc_byte = 8'h00;
    bc_cle  = 1'b0;
    bc_ale  = 1'b0;
    bc_need = 1'b0;
    case (state_q)
      S_SEQ: begin
        bc_cle  = 1'b1;
        bc_need = 1'b1;
        bc_byte = plane_q ? `NCPS_CMD_PLANE2 : `NCPS_CMD_DIN;
      end
      S_ADDR: begin
        bc_ale  = 1'b1;
        bc_need = 1'b1;
        case (idx_q)
          3'd2:    bc_byte = row[7:0];
          3'd3:    bc_byte = row[15:8];
          3'd4:    bc_byte = {7'h00, row[16]};
          default: bc_byte = 8'h00;
        endcase
      end
      S_DATA: begin
        bc_need = pend_q;
        bc_byte = data_q;
      end
      S_END: begin
        bc_cle  = 1'b1;
        bc_need = 1'b1;
        if (multi_q && !plane_q) begin
          bc_byte = `NCPS_CMD_PLANE_SW;
        end else if (final_q) begin
          bc_byte = `NCPS_CMD_FINAL;
        end else begin
          bc_byte = `NCPS_CMD_CACHE;
        end
      end
      S_SCMD: begin
        bc_cle  = 1'b1;
        bc_need = 1'b1;
        bc_byte = multi_q ? `NCPS_CMD_STAT_MP : `NCPS_CMD_STAT;
      end
      S_SRD: begin
        bc_need = 1'b1;
      end
      default: begin
        bc_need = 1'b0;
      end
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rb_s1_q <= 1'b0;
      rb_s2_q <= 1'b0;
    end else begin
      rb_s1_q <= ready_busy_pin;
      rb_s2_q <= rb_s1_q;
    end
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      state_q      <= S_IDLE;
      ret_q        <= S_IDLE;
      idx_q        <= 3'd0;
      cnt_q        <= 12'h000;
      len_q        <= `NCPS_LEN_RST;
      plane_q      <= 1'b0;
      final_q      <= 1'b0;
      multi_q      <= 1'b0;
      stonly_q     <= 1'b0;
      row_a_q      <= 17'h00000;
      row_b_q      <= 17'h00000;
      data_q       <= 8'h00;
      pend_q       <= 1'b0;
      stat_q       <= 8'h00;
      open_q       <= 1'b0;
      open_multi_q <= 1'b0;
      open_blk_q   <= 11'h000;
      err_q        <= 1'b0;
      launch_q     <= 1'b0;
      wb_q         <= 8'h00;
    end else begin
      if (bc_start) begin
        launch_q <= 1'b1;
      end else if (bc_done) begin
        launch_q <= 1'b0;
      end
      if (access && pwrite && pready) begin
        if (paddr == `NCPS_OFF_ROW_A && state_q == S_IDLE) begin
          row_a_q <= pwdata[16:0];
        end
        if (paddr == `NCPS_OFF_ROW_B && state_q == S_IDLE) begin
          row_b_q <= pwdata[16:0];
        end
        if (paddr == `NCPS_OFF_LEN && state_q == S_IDLE) begin
          len_q <= pwdata[11:0];
        end
        if (paddr == `NCPS_OFF_DATA && state_q == S_DATA) begin
          data_q <= pwdata[7:0];
          pend_q <= 1'b1;
        end
      end
      // A refused start sets the error flag; setting wins over a same-cycle clear
      if (go && !go_ok) begin
        err_q <= 1'b1;
      end else if (access && pwrite && paddr == `NCPS_OFF_STATUS && pwdata[`NCPS_ST_ERR]) begin
        err_q <= 1'b0;
      end
      case (state_q)
        S_IDLE: begin
          if (go && go_ok) begin
            final_q  <= pwdata[`NCPS_CTRL_FINAL];
            multi_q  <= go_multi;
            stonly_q <= go_stat;
            plane_q  <= 1'b0;
            if (go_stat) begin
              state_q <= S_SCMD;
            end else begin
              open_q       <= ~pwdata[`NCPS_CTRL_FINAL];
              open_multi_q <= go_multi;
              open_blk_q   <= row_a_q[16:6];
              wb_q         <= WB_CYC;
              ret_q        <= S_SEQ;
              state_q      <= S_WAIT;
            end
          end
        end
        S_WAIT: begin
          // Skip the unsettled busy window before trusting the pin
          if (wb_q < WB_CYC) begin
            wb_q <= wb_q + 8'h01;
          end else if (rb_s2_q) begin
            state_q <= ret_q;
          end
        end
        S_SEQ: begin
          if (bc_done) begin
            idx_q   <= 3'd0;
            state_q <= S_ADDR;
          end
        end
        S_ADDR: begin
          if (bc_done) begin
            if (idx_q == 3'd4) begin
              cnt_q   <= 12'h000;
              state_q <= S_DATA;
            end else begin
              idx_q <= idx_q + 3'd1;
            end
          end
        end
        S_DATA: begin
          if (bc_done) begin
            pend_q <= 1'b0;
            if (cnt_q == len_q - 12'h001) begin
              state_q <= S_END;
            end else begin
              cnt_q <= cnt_q + 12'h001;
            end
          end
        end
        S_END: begin
          if (bc_done) begin
            wb_q    <= 8'h00;
            state_q <= S_WAIT;
            if (multi_q && !plane_q) begin
              plane_q <= 1'b1;
              ret_q   <= S_SEQ;
            end else begin
              ret_q <= S_SCMD;
            end
          end
        end
        S_SCMD: begin
          if (bc_done) begin
            state_q <= S_SRD;
          end
        end
        S_SRD: begin
          if (bc_done) begin
            stat_q  <= bc_rbyte;
            state_q <= S_IDLE;
          end
        end
        default: begin
          state_q <= S_IDLE;
        end
      endcase
    end
  end

  always @* begin
    prdata  = 32'h00000000;
    pslverr = 1'b0;
    case (paddr)
      `NCPS_OFF_CTRL: begin
        prdata[3:1] = {stonly_q, multi_q, final_q};
        pslverr     = go & ~go_ok;
      end
      `NCPS_OFF_ROW_A:  prdata[16:0] = row_a_q;
      `NCPS_OFF_ROW_B:  prdata[16:0] = row_b_q;
      `NCPS_OFF_DATA:   pslverr = pwrite & (state_q != S_DATA);
      `NCPS_OFF_LEN:    prdata[11:0] = len_q;
      `NCPS_OFF_STATUS: begin
        prdata[7:0] = stat_q;
        prdata[`NCPS_ST_BUSY] = busy;
        prdata[`NCPS_ST_RB]   = rb_s2_q;
        prdata[`NCPS_ST_OPEN] = open_q;
        prdata[`NCPS_ST_ERR]  = err_q;
        prdata[`NCPS_ST_OPEN_MULTI] = open_multi_q;
        // Pass/fail bits 16 and 17 are shown only while the matching ready bit qualifies them; bits 18 to 20 are not gated
        prdata[16] = stat_q[0] & stat_q[5];
        prdata[17] = stat_q[1] & stat_q[6];
        prdata[18] = stat_q[1] | stat_q[2];
        prdata[20:19] = stat_q[4:3];
      end
      default: pslverr = 1'b1;
    endcase
    if (!access) begin
      pslverr = 1'b0;
    end
  end

  ncps_byte_cycle u_cycle (
    .pclk         (pclk),
    .presetn      (presetn),
    .start        (bc_start),
    .rd           (state_q == S_SRD),
    .cle_in       (bc_cle),
    .ale_in       (bc_ale),
    .wbyte        (bc_byte),
    .done         (bc_done),
    .rbyte        (bc_rbyte),
    .nand_cle     (nand_cle),
    .nand_ale     (nand_ale),
    .nand_we_n    (nand_we_n),
    .nand_re_n    (nand_re_n),
    .nand_io_out  (nand_io_out),
    .nand_io_oe_n (nand_io_oe_n),
    .nand_io_in   (nand_io_in)
  );
endmodule // ncps_host

// >>> verification/ncps_checker.sv
module ncps_checker (
  input logic       pclk,
  input logic       presetn,
  input logic       nand_ce_n,
  input logic       nand_cle,
  input logic       nand_ale,
  input logic       nand_we_n,
  input logic       nand_re_n,
  input logic [7:0] nand_io_out,
  input logic       nand_io_oe_n,
  input logic       ready_busy_pin,
  input logic       busy
);
  timeunit 1ns;
  timeprecision 100ps;
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  // Byte is still held at the strobe rise, so the opcode is seen there
  wire is_prog = nand_cle && (nand_io_out == 8'h15 || nand_io_out == 8'h10);
  logic       we_q     = 1'b1;
  logic [7:0] last_cmd = 8'h00;
  logic [2:0] a_idx    = 3'h0;
  logic [5:0] pg_a     = 6'h00;

  // Track the last command and the first plane's page bits at each strobe rise
  always @(posedge pclk) begin
    we_q <= nand_we_n;
    if (nand_we_n && !we_q && nand_cle) begin
      last_cmd <= nand_io_out;
      a_idx    <= 3'h0;
    end else if (nand_we_n && !we_q && nand_ale) begin
      a_idx <= a_idx + 3'h1;
      if (a_idx == 3'h2 && last_cmd == 8'h80) begin
        pg_a <= nand_io_out[5:0];
      end
    end
  end

  a_we_pulse_shape: assert property ($fell(nand_we_n) |-> !nand_we_n [*4] ##1 nand_we_n [*2])
    else $error("write strobe shape wrong");
  a_re_pulse_shape: assert property ($fell(nand_re_n) |-> !nand_re_n [*4] ##1 nand_re_n [*2])
    else $error("read strobe shape wrong");
  a_drive_on_write: assert property (!nand_we_n |-> !nand_io_oe_n && !nand_ce_n)
    else $error("bus not driven during write");
  a_release_on_read: assert property (!nand_re_n |-> nand_io_oe_n && !nand_ce_n)
    else $error("bus driven during read");
  a_ce_follows_busy: assert property ((!nand_we_n || !nand_re_n) |-> busy && !nand_ce_n)
    else $error("strobe outside a busy selected window");
  a_cmd_set_legal: assert property ($fell(nand_we_n) && nand_cle |->
    nand_io_out inside {8'h80, 8'h81, 8'h11, 8'h15, 8'h10, 8'h70, 8'h71})
    else $error("command outside the program sequence");
  a_plane_switch_seq: assert property ($fell(nand_we_n) && nand_cle && last_cmd == 8'h11 |->
    nand_io_out == 8'h81 || nand_io_out == 8'h70 || nand_io_out == 8'h71 || nand_io_out == 8'hff)
    else $error("wrong command after plane switch");
  a_same_page_bits: assert property ($rose(nand_we_n) && nand_ale && a_idx == 3'h2 &&
    last_cmd == 8'h81 |-> nand_io_out[5:0] == pg_a)
    else $error("second plane page bits differ");
  a_latch_exclusive: assert property (!nand_we_n |-> !(nand_cle && nand_ale))
    else $error("command and address latch together");
  a_wait_after_prog: assert property ($rose(nand_we_n) && is_prog |-> nand_we_n [*4])
    else $error("strobe too soon after program command");
  a_cmd_when_ready: assert property ($fell(nand_we_n) && nand_cle |-> $past(ready_busy_pin, 2))
    else $error("command issued while device busy");
  a_status_follows: assert property ($rose(nand_we_n) && is_prog |->
    ##[1:1000] ($fell(nand_we_n) && nand_cle && nand_io_out[7:1] == 7'h38))
    else $error("no status read after program command");
endmodule // ncps_checker

bind ncps_host ncps_checker ncps_checker_i (.pclk(pclk), .presetn(presetn),
  .nand_ce_n(nand_ce_n), .nand_cle(nand_cle), .nand_ale(nand_ale), .nand_we_n(nand_we_n),
  .nand_re_n(nand_re_n), .nand_io_out(nand_io_out), .nand_io_oe_n(nand_io_oe_n),
  .ready_busy_pin(ready_busy_pin), .busy(busy));

// >>> verification/ncps_nand_model.sv
module ncps_nand_model (
  input  logic       pclk,
  input  logic       nand_ce_n,
  input  logic       nand_cle,
  input  logic       nand_we_n,
  input  logic       nand_re_n,
  input  logic [7:0] nand_io_out,
  output logic [7:0] nand_io_in,
  output logic       ready_busy_pin,
  input  logic [1:0] fail,
  input  logic [9:0] prog_cyc
);
  timeunit 1ns;
  timeprecision 100ps;
  localparam int XFER = 8;
  logic [7:0] cmd = 8'h00;
  logic       fin = 1'b0, req = 1'b0, ack = 1'b0;
  logic [1:0] cur = 2'b00, prv = 2'b00;
  int         bsy = 0, prog = 0;
  wire        cache_rdy = (bsy == 0) && (req == ack);
  wire        pb_rdy = (prog == 0) && (req == ack);
  wire [7:0]  stat = (cmd == 8'h71) ? {1'b1, cache_rdy, pb_rdy, prv, cur, |cur}
                                    : {1'b1, cache_rdy, pb_rdy, 3'b000, |prv, |cur};
  // No pull on the bus: a released bus shows the inverse, never a stale byte
  assign nand_io_in = (!nand_re_n && !nand_ce_n) ? stat : ~stat;
  assign ready_busy_pin = cache_rdy;

  always @(posedge nand_we_n) begin
    if (!nand_ce_n && nand_cle) begin
      cmd <= nand_io_out;
      if (nand_io_out == 8'h15 || nand_io_out == 8'h10) begin
        fin <= (nand_io_out == 8'h10);
        req <= !req;
      end
    end
  end

  always @(posedge pclk) begin
    if (req != ack) begin
      ack <= req;
      prv <= cur;
      cur <= fail;
      bsy <= fin ? prog + prog_cyc : prog + XFER;
      prog <= prog + prog_cyc;
    end else begin
      if (bsy != 0) bsy <= bsy - 1;
      if (prog != 0) prog <= prog - 1;
    end
  end
endmodule // ncps_nand_model

// >>> verification/ncps_tb_top.sv
module ncps_tb_top;
  timeunit 1ns;
  timeprecision 100ps;
  logic        pclk = 1'b0, presetn = 1'b0, psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  logic [7:0]  paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic        pready, pslverr, err, ce_n, cle, ale, we_n, re_n, rb, busy, wp_n;
  logic [7:0]  io_out, io_in;
  logic [1:0]  fail = 2'b00, exp_cur = 2'b00, exp_prv = 2'b00;
  logic [9:0]  prog_cyc = 10'h0c8;
  int          n_errors = 0, tests_run = 0, cycles = 0;

  always #12.5 pclk = ~pclk;

  ncps_host ncps_host_i (.pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .nand_ce_n(ce_n), .nand_cle(cle), .nand_ale(ale), .nand_we_n(we_n),
    .nand_re_n(re_n), .nand_wp_n(wp_n), .nand_io_out(io_out), .nand_io_oe_n(),
    .nand_io_in(io_in), .ready_busy_pin(rb), .busy(busy));
  ncps_nand_model ncps_nand_model_i (.pclk(pclk), .nand_ce_n(ce_n), .nand_cle(cle),
    .nand_we_n(we_n), .nand_re_n(re_n), .nand_io_out(io_out), .nand_io_in(io_in),
    .ready_busy_pin(rb), .fail(fail), .prog_cyc(prog_cyc));

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    tests_run++;
    if (seen !== exp) begin
      n_errors++;
      $display("[FAIL] t=%0t seen=%h expected=%h", $time, seen, exp);
    end
  endtask

  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= wr;
    paddr <= a;
    pwdata <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk iff pready);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wait_idle;
    int n;
    n = 0;
    do apb(1'b0, 8'h14, 32'h0); while (rd[8] !== 1'b0 && ++n < 500);
  endtask

  function automatic logic [7:0] sbyte(input logic multi, input logic pb);
    if (multi) return {1'b1, 1'b1, pb, exp_prv, exp_cur, |exp_cur};
    return {1'b1, 1'b1, pb, 3'b000, |exp_prv, |exp_cur};
  endfunction

  // One program step; a final step leaves the page buffer ready
  task automatic step(input logic [3:0] ctrl, input int nbytes, input logic [1:0] f);
    logic [7:0] e;
    int         k;
    fail <= f;
    apb(1'b1, 8'h00, {28'h0, ctrl});
    check(err, 1'b0);
    for (int i = 0; i < nbytes; i++) begin
      k = 0;
      // Bytes are refused until the controller has reached its data phase
      do apb(1'b1, 8'h0c, 32'h0000_00a5 ^ i); while (err && ++k < 300);
      check(err, 1'b0);
    end
    wait_idle();
    exp_prv = exp_cur;
    exp_cur = f;
    e = sbyte(ctrl[2], ctrl[1]);
    check(rd[7:0], e);
    check(rd[20:16], {e[4:3], e[1] | e[2], e[1] & e[6], e[0] & e[5]});
    check(rd[12:10], {ctrl[2], 1'b0, ~ctrl[1]});
  endtask

  task automatic note(input string s);
    $display("Test %s finished, mismatches so far %0d", s, n_errors);
  endtask

  task automatic t_reset;
    apb(1'b0, 8'h14, 32'h0);
    check(rd, 32'h0000_0200);
    check(wp_n, 1'b1);
    apb(1'b0, 8'h10, 32'h0);
    check(rd, 32'h0000_0100);
    apb(1'b0, 8'h18, 32'h0);
    check(err, 1'b1);
    apb(1'b1, 8'h0c, 32'h0000_0011);
    check(err, 1'b1);
    apb(1'b1, 8'h10, 32'h0000_0002);
    note("reset");
  endtask

  // Slow program time so each later cache step waits on the running page
  task automatic t_cache;
    for (int p = 0; p < 3; p++) begin
      apb(1'b1, 8'h04, 32'h0000_0100 + p);
      step((p == 2) ? 4'h3 : 4'h1, 2, (p == 1) ? 2'b01 : 2'b00);
    end
    note("cache");
  endtask

  task automatic t_block;
    apb(1'b1, 8'h04, 32'h0000_0140);
    step(4'h1, 2, 2'b00);
    apb(1'b1, 8'h04, 32'h0000_0180);
    apb(1'b1, 8'h00, 32'h0000_0001);
    check(err, 1'b1);
    apb(1'b0, 8'h14, 32'h0);
    check(rd[11:10], 2'b11);
    apb(1'b1, 8'h14, 32'h0000_0800);
    apb(1'b1, 8'h04, 32'h0000_0141);
    prog_cyc <= 10'h00a;
    step(4'h3, 2, 2'b00);
    check(rd[11], 1'b0);
    note("block");
  endtask

  task automatic t_multi;
    prog_cyc <= 10'h0c8;
    apb(1'b1, 8'h04, 32'h0000_0043);
    apb(1'b1, 8'h08, 32'h0000_00c0);
    apb(1'b1, 8'h00, 32'h0000_0005);
    check(err, 1'b1);
    apb(1'b1, 8'h14, 32'h0000_0800);
    apb(1'b1, 8'h08, 32'h0000_0080);
    step(4'h5, 4, 2'b10);
    apb(1'b1, 8'h04, 32'h0000_0044);
    step(4'h7, 4, 2'b01);
    note("multi");
  endtask

  task automatic t_stat;
    for (int m = 0; m < 2; m++) begin
      apb(1'b1, 8'h00, m ? 32'h0000_000d : 32'h0000_0009);
      wait_idle();
      check(rd[7:0], sbyte(m[0], 1'b1));
    end
    note("status");
  endtask

  task automatic give_verdict;
    $display("Compares %0d, mismatches %0d", tests_run, n_errors);
    if (n_errors == 0 && tests_run > 0) $display("Run complete: PASS");
    else $display("Run complete: FAIL");
    $finish;
  endtask

  // Whole run needs roughly 2000 cycles
  always @(posedge pclk) begin
    cycles <= cycles + 1;
    if (cycles == 60000) begin
      n_errors++;
      give_verdict();
    end
  end

  initial begin
    repeat (4) @(posedge pclk);
    presetn <= 1'b1;
    t_reset();
    t_cache();
    t_block();
    t_multi();
    t_stat();
    give_verdict();
  end
endmodule // ncps_tb_top
